// File: tcx_config_control.sv
`timescale 1ns/1ns
// Function
// - Level zero selects pins, else registers.
// - Two enables plus orientation decode configuration.
// - USB uses pair one, or two flipped.
// - DP lanes fed from pairs per orientation.
// - Sideband map follows override field.
// - DP lanes pass only with hot-plug.
// - Lane-off bits act crosswise in four-lane.
// - Gain field is upper code over lower.
// - Sixteen gain settings per path or lane.
// - Link tracker runs only with USB enabled.
// - Disconnect to U0 on both terminations.
// - U0 to U1 on idle both ports.
// - U1 keeps terminations and common mode.
// - U2/U3 polls detection, LFPS wakes to U0.
// - Power-good within 500 microseconds.
// - Control pins debounced, at most 16 ms.
// - Target address from two four-level pins.
// - Defaults to USB until enable pin pulsed.
// - Pin mode: no snoop, all lanes.
// - Four-level inputs latched, then bias removed.
module tcx_config_control
  import tcx_pkg::*;
#(
  parameter int PG_CYCLES = PG_DELAY_CYC,
  parameter int DB_CYCLES = DEBOUNCE_CYC
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [1:0] mode_level,
  input wire logic [3:0] upstream_gain_pins,
  input wire logic [3:0] downstream_gain_pins,
  input wire logic [3:0] lane_gain_pins,
  input wire logic dp_enable_pin,
  input wire logic usb_enable_pin,
  input wire logic orientation_pin,
  input wire logic hot_plug_input,
  input wire logic [3:0] snoop_lane_mask,
  input wire logic far_term_up,
  input wire logic far_term_down,
  input wire logic idle_up,
  input wire logic idle_down,
  input wire logic lfps_valid,
  output logic power_good,
  output logic bias_enable,
  output logic [6:0] target_addr,
  output logic [1:0] usb_pair,
  output tcx_src_t lane0_source,
  output tcx_src_t lane1_source,
  output tcx_src_t lane2_source,
  output tcx_src_t lane3_source,
  output logic [3:0] lane_active,
  output logic [1:0] sbu_map,
  output logic [3:0] lane0_gain,
  output logic [3:0] lane1_gain,
  output logic [3:0] lane2_gain,
  output logic [3:0] lane3_gain,
  output logic [3:0] upstream1_gain,
  output logic [3:0] upstream2_gain,
  output logic [3:0] downstream_gain,
  output tcx_link_t link_state,
  output logic rx_term_en,
  output logic tx_cm_en,
  output logic redrive_en,
  output logic rx_detect
);
  localparam int PGW = $clog2(PG_CYCLES + 1);
  localparam int DBW = $clog2(DB_CYCLES + 1);
  localparam int HLW = $clog2(CFG_HOLD_CYC + 1);
  localparam int TMW = $clog2(RXDET_CYC + U1_IDLE_CYC + 1);

  function automatic logic [6:0] addr_from(input logic [1:0] hi,
                                           input logic [1:0] lo);
    logic [6:0] pat;
    pat = (hi == LVL_0) ? ADDR_HI_0 : (hi == LVL_R) ? ADDR_HI_R :
          (hi == LVL_F) ? ADDR_HI_F : ADDR_HI_1;
    return pat | {5'h00, lo};
  endfunction : addr_from

  function automatic tcx_src_t lane_src(input logic [1:0] lane,
                                        input logic flip);
    tcx_src_t s;
    case (lane)
      2'h0: s = flip ? SRC_TX1 : SRC_TX2;
      2'h1: s = flip ? SRC_RX1 : SRC_RX2;
      2'h2: s = flip ? SRC_RX2 : SRC_RX1;
      default: s = flip ? SRC_TX2 : SRC_TX1;
    endcase
    return s;
  endfunction : lane_src

  // Power-good timer and four-level capture.
  logic [PGW-1:0] pg_cnt;
  logic [HLW-1:0] hold_cnt;
  logic pin_mode;
  logic [3:0] up_lat, down_lat, lane_lat;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_cnt <= '0;
      power_good <= 1'b0;
    end
    else if (!power_good)
    begin
      pg_cnt <= pg_cnt + 1'b1;
      power_good <= (pg_cnt == PGW'(PG_CYCLES - 1));
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_mode <= 1'b0;
      up_lat <= 4'h0;
      down_lat <= 4'h0;
      lane_lat <= 4'h0;
      target_addr <= 7'h00;
      hold_cnt <= '0;
      bias_enable <= 1'b1;
    end
    else if (power_good && bias_enable)
    begin
      if (hold_cnt == '0)
      begin
        pin_mode <= (mode_level == LVL_0);
        up_lat <= upstream_gain_pins;
        down_lat <= downstream_gain_pins;
        lane_lat <= lane_gain_pins;
        target_addr <= addr_from(lane_gain_pins[1:0],
                                 downstream_gain_pins[1:0]);
      end
      hold_cnt <= hold_cnt + 1'b1;
      bias_enable <= (hold_cnt != HLW'(CFG_HOLD_CYC - 1));
    end
  end

  // Control pin debounce: a level is adopted once stable for the window.
  logic [2:0] pin_raw, deb;
  logic [DBW-1:0] dcnt [3];
  logic usb_default;
  assign pin_raw = {orientation_pin, dp_enable_pin, usb_enable_pin};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      deb <= 3'h0;
      for (int i = 0; i < 3; i++)
        dcnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (pin_raw[i] == deb[i])
          dcnt[i] <= '0;
        else if (dcnt[i] == DBW'(DB_CYCLES - 1))
        begin
          deb[i] <= pin_raw[i];
          dcnt[i] <= '0;
        end
        else
          dcnt[i] <= dcnt[i] + 1'b1;
      end
    end
  end

  // USB stays on after power-up until the enable pin falls once.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      usb_default <= 1'b1;
    else if (deb[0] && !pin_raw[0] && dcnt[0] == DBW'(DB_CYCLES - 1))
      usb_default <= 1'b0;
  end

  // Register file.
  logic [7:0] cfg_reg, gain01, gain23, up_gain, down_gain;
  logic [3:0] lane_off;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg <= CONFIG_RST;
      lane_off <= LANE_OFF_RST;
      gain01 <= GAIN_RST;
      gain23 <= GAIN_RST;
      up_gain <= GAIN_RST;
      down_gain <= GAIN_RST;
    end
    else if (wr)
    begin
      case (addr)
        REG_CONFIG: cfg_reg <= {2'h0, wdata[5:0]};
        REG_LANE_OFF: lane_off <= wdata[3:0];
        REG_LANE_GAIN01: gain01 <= wdata;
        REG_LANE_GAIN23: gain23 <= wdata;
        REG_UP_GAIN: up_gain <= wdata;
        REG_DOWN_GAIN: down_gain <= {4'h0, wdata[3:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        REG_CONFIG: rdata <= cfg_reg;
        REG_LANE_OFF: rdata <= {4'h0, lane_off};
        REG_LANE_GAIN01: rdata <= gain01;
        REG_LANE_GAIN23: rdata <= gain23;
        REG_UP_GAIN: rdata <= up_gain;
        REG_DOWN_GAIN: rdata <= down_gain;
        REG_STATUS: rdata <= {bias_enable, power_good, pin_mode, deb,
                              link_state};
        REG_TARGET: rdata <= {1'b0, target_addr};
        default: rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // Effective configuration.
  logic sel_usb, sel_dp, sel_flip, snoop_off, four_lane, usb_on, dp_on;
  logic [1:0] sbu_ovr;
  logic [3:0] lane_mask;
  always_comb
  begin
    sel_usb = pin_mode ? (deb[0] | usb_default) : cfg_reg[CFG_USB_BIT];
    sel_dp = pin_mode ? deb[1] : cfg_reg[CFG_DP_BIT];
    sel_flip = pin_mode ? deb[2] : cfg_reg[CFG_FLIP_BIT];
    sbu_ovr = pin_mode ? SBU_AUTO : cfg_reg[CFG_SBU_LSB +: 2];
    snoop_off = pin_mode | cfg_reg[CFG_SNOOP_OFF_BIT];
    four_lane = sel_dp & ~sel_usb;
    usb_on = sel_usb & power_good;
    dp_on = sel_dp & hot_plug_input & power_good;
    if (pin_mode)
      lane_mask = 4'hF;
    else if (!snoop_off)
      lane_mask = snoop_lane_mask;
    else if (four_lane)
      lane_mask = ~{lane_off[0], lane_off[1], lane_off[2],
                    lane_off[3]};
    else
      lane_mask = ~lane_off;
  end

  logic [1:0] next_sbu;
  always_comb
  begin
    case (sbu_ovr)
      SBU_AUTO: next_sbu = !sel_dp ? SBU_OPEN :
                           sel_flip ? SBU_SWAPPED : SBU_STRAIGHT;
      SBU_STRAIGHT: next_sbu = SBU_STRAIGHT;
      SBU_SWAPPED: next_sbu = SBU_SWAPPED;
      default: next_sbu = SBU_OPEN;
    endcase
  end

  // Routing outputs.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      usb_pair <= PAIR_NONE;
      lane0_source <= SRC_NONE;
      lane1_source <= SRC_NONE;
      lane2_source <= SRC_NONE;
      lane3_source <= SRC_NONE;
      lane_active <= 4'h0;
      sbu_map <= SBU_OPEN;
    end
    else
    begin
      usb_pair <= !sel_usb ? PAIR_NONE :
                  sel_flip ? PAIR_TWO : PAIR_ONE;
      lane0_source <= sel_dp ? lane_src(2'h0, sel_flip) : SRC_NONE;
      lane1_source <= sel_dp ? lane_src(2'h1, sel_flip) : SRC_NONE;
      lane2_source <= four_lane ? lane_src(2'h2, sel_flip) : SRC_NONE;
      lane3_source <= four_lane ? lane_src(2'h3, sel_flip) : SRC_NONE;
      lane_active <= dp_on ? (lane_mask & (four_lane ? 4'hF : 4'h3))
                           : 4'h0;
      sbu_map <= next_sbu;
    end
  end

  // Equalization codes.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lane0_gain <= 4'h0;
      lane1_gain <= 4'h0;
      lane2_gain <= 4'h0;
      lane3_gain <= 4'h0;
      upstream1_gain <= 4'h0;
      upstream2_gain <= 4'h0;
      downstream_gain <= 4'h0;
    end
    else if (pin_mode)
    begin
      lane0_gain <= lane_lat;
      lane1_gain <= lane_lat;
      lane2_gain <= lane_lat;
      lane3_gain <= lane_lat;
      upstream1_gain <= up_lat;
      upstream2_gain <= up_lat;
      downstream_gain <= down_lat;
    end
    else
    begin
      lane0_gain <= gain01[3:0];
      lane1_gain <= gain01[7:4];
      lane2_gain <= gain23[3:0];
      lane3_gain <= gain23[7:4];
      upstream1_gain <= up_gain[3:0];
      upstream2_gain <= up_gain[7:4];
      downstream_gain <= down_gain[3:0];
    end
  end

  // USB link-state tracker.
  tcx_link_t next_state;
  logic [TMW-1:0] tmr;
  logic terms_ok, both_idle, tmr_done;
  assign terms_ok = far_term_up & far_term_down;
  assign both_idle = idle_up & idle_down;
  assign tmr_done = (link_state == LINK_U1) ?
                    (tmr == TMW'(U1_IDLE_CYC - 1)) :
                    (tmr == TMW'(RXDET_CYC - 1));
  always_comb
  begin
    next_state = link_state;
    if (!usb_on)
      next_state = LINK_DISC;
    else
    begin
      case (link_state)
        LINK_DISC: if (terms_ok) next_state = LINK_U0;
        LINK_U0: if (both_idle) next_state = LINK_U1;
        LINK_U1:
          if (lfps_valid || !both_idle)
            next_state = LINK_U0;
          else if (tmr_done)
            next_state = LINK_U23;
        LINK_U23:
          if (rx_detect && !terms_ok)
            next_state = LINK_DISC;
          else if (lfps_valid)
            next_state = LINK_U0;
        default: next_state = LINK_DISC;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_state <= LINK_DISC;
      tmr <= '0;
      rx_detect <= 1'b0;
      rx_term_en <= 1'b0;
      tx_cm_en <= 1'b0;
      redrive_en <= 1'b0;
    end
    else
    begin
      link_state <= next_state;
      tmr <= (next_state != link_state || tmr_done) ? '0 : tmr + 1'b1;
      rx_detect <= (next_state == LINK_U23) && (link_state == LINK_U23)
                   && tmr_done;
      rx_term_en <= (next_state != LINK_DISC);
      tx_cm_en <= (next_state == LINK_U0) ||
                  (next_state == LINK_U1);
      redrive_en <= (next_state == LINK_U0);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_idle_both;
    usb_on && both_idle;
  endsequence
  sequence s_in_u0;
    link_state == LINK_U0 && redrive_en && tx_cm_en;
  endsequence

  a_disc_wake: assert property (link_state == LINK_DISC && usb_on &&
    terms_ok |=> s_in_u0) else $error("disconnect did not wake");
  a_idle_to_u1: assert property (link_state == LINK_U0 ##0 s_idle_both
    |=> link_state == LINK_U1 && !redrive_en)
    else $error("idle did not enter U1");
  a_u1_terms: assert property (link_state == LINK_U1 |->
    rx_term_en && tx_cm_en) else $error("U1 dropped termination");
  a_u23_lfps: assert property (link_state == LINK_U23 && usb_on &&
    lfps_valid && !rx_detect |=> s_in_u0)
    else $error("LFPS did not wake");
  a_u23_power: assert property (link_state == LINK_U23 |->
    rx_term_en && !tx_cm_en) else $error("U2/U3 outputs wrong");
  a_usb_off: assert property (!usb_on |=> link_state == LINK_DISC &&
    !rx_term_en) else $error("tracker ran without USB");
  a_dp_gate: assert property (lane_active != 4'h0 |->
    $past(hot_plug_input) && $past(sel_dp))
    else $error("DP lane active without hot-plug");
  a_lane_cross: assert property (!pin_mode && snoop_off && four_lane &&
    dp_on |=> lane_active == ~{$past(lane_off[0]), $past(lane_off[1]),
    $past(lane_off[2]), $past(lane_off[3])})
    else $error("lane-off bits not crosswise");
  a_usb_route: assert property (sel_usb && sel_flip |=>
    usb_pair == PAIR_TWO) else $error("flipped USB pair wrong");
  a_sbu_open: assert property (sbu_ovr == 2'h3 |=> sbu_map == SBU_OPEN)
    else $error("sideband not open");
  a_gain_pins: assert property (pin_mode && $stable(pin_mode) |=>
    lane3_gain == $past(lane_lat) && upstream2_gain == $past(up_lat))
    else $error("pin gain code wrong");
  a_pg_time: assert property ($rose(power_good) |->
    $past(pg_cnt) == PGW'(PG_CYCLES - 1))
    else $error("power-good timing wrong");
  a_deb_wait: assert property ($changed(deb[1]) |->
    $past(dcnt[1]) == DBW'(DB_CYCLES - 1))
    else $error("debounce window skipped");
endmodule : tcx_config_control

// File: tcx_config_control_tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
      bad_count++; \
      $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module tcx_config_control_tb
  import tcx_pkg::*;
;
  logic clk, rst_n, wr, rd, dp_enable_pin, usb_enable_pin, orientation_pin;
  logic hot_plug_input, power_good, bias_enable, rx_term_en, tx_cm_en;
  logic redrive_en, rx_detect, want_term, want_idle, want_lfps;
  logic far_term_up, far_term_down, idle_up, idle_down, lfps_valid;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] mode_level, usb_pair, sbu_map;
  logic [2:0] lag;
  logic [3:0] upstream_gain_pins, downstream_gain_pins, lane_gain_pins;
  logic [3:0] snoop_lane_mask, lane_active, lane0_gain, lane1_gain;
  logic [3:0] lane2_gain, lane3_gain, upstream1_gain, upstream2_gain;
  logic [3:0] downstream_gain, off, u, d, l;
  logic [6:0] target_addr;
  logic [7:0] cfg;
  logic [31:0] g;
  tcx_src_t lane0_source, lane1_source, lane2_source, lane3_source;
  tcx_link_t link_state;
  int bad_count, tests_run, cycles, i;
  logic det_seen;

  tcx_config_control #(.PG_CYCLES(20), .DB_CYCLES(8)) tcx_config_control_i (
    .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .mode_level,
    .upstream_gain_pins, .downstream_gain_pins, .lane_gain_pins,
    .dp_enable_pin, .usb_enable_pin, .orientation_pin, .hot_plug_input,
    .snoop_lane_mask, .far_term_up, .far_term_down, .idle_up, .idle_down,
    .lfps_valid, .power_good, .bias_enable, .target_addr, .usb_pair,
    .lane0_source, .lane1_source, .lane2_source, .lane3_source,
    .lane_active, .sbu_map, .lane0_gain, .lane1_gain, .lane2_gain,
    .lane3_gain, .upstream1_gain, .upstream2_gain, .downstream_gain,
    .link_state, .rx_term_en, .tx_cm_en, .redrive_en, .rx_detect);

  tcx_link_partner tcx_link_partner_i (.clk, .want_term, .want_idle,
    .want_lfps, .lag, .far_term_up, .far_term_down, .idle_up, .idle_down,
    .lfps_valid);

  always #5 clk = ~clk;

  function automatic logic [13:0] exp_route(input logic dp, usb, flip);
    logic [11:0] s;
    if (dp && !usb)
      s = flip ? {3'h1, 3'h2, 3'h4, 3'h3} : {3'h3, 3'h4, 3'h2, 3'h1};
    else if (dp)
      s = flip ? {3'h1, 3'h2, 6'h00} : {3'h3, 3'h4, 6'h00};
    else
      s = 12'h000;
    return {usb ? (flip ? 2'h2 : 2'h1) : 2'h0, s};
  endfunction : exp_route

  function automatic logic [1:0] exp_sbu(input logic [1:0] ov,
                                         input logic dp, flip);
    if (ov == 2'h0)
      return dp ? (flip ? 2'h2 : 2'h1) : 2'h0;
    return (ov == 2'h3) ? 2'h0 : ov;
  endfunction : exp_sbu

  function automatic logic [6:0] exp_addr(input logic [1:0] hi, lo);
    logic [6:0] a [4] = '{7'h44, 7'h20, 7'h10, 7'h0C};
    return a[hi] | {5'h00, lo};
  endfunction : exp_addr

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic powerup(input logic [1:0] ml);
    int n;
    @(posedge clk);
    rst_n <= 1'b0;
    mode_level <= ml;
    upstream_gain_pins <= u;
    downstream_gain_pins <= d;
    lane_gain_pins <= l;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("power_good", 1'b0, power_good)
    n = 0;
    while (power_good !== 1'b1 && n < 30)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("pg_delay", 1'b1, n <= 22)
    repeat (3) @(posedge clk);
  endtask : powerup

  task automatic wr_reg(input logic [7:0] a, dd);
    wr <= 1'b1;
    addr <= a;
    wdata <= dd;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, ex, m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", ex & m, rdata & m)
  endtask : rd_chk

  task automatic wait_link(input tcx_link_t s, input int max);
    int n;
    n = 0;
    while (link_state !== s && n < max)
    begin
      @(posedge clk);
      #1;
      n++;
      if (rx_detect === 1'b1)
        det_seen = 1'b1;
    end
    `CHK("link_state", s, link_state)
  endtask : wait_link

  task automatic pulse_lfps;
    @(posedge clk);
    want_lfps <= 1'b1;
    @(posedge clk);
    want_lfps <= 1'b0;
  endtask : pulse_lfps

  // Cuts a hung run short; the tests need well under 10000 cycles.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  initial
  begin
    {clk, rst_n, wr, rd, dp_enable_pin, usb_enable_pin} = 6'h00;
    {orientation_pin, hot_plug_input, want_term, want_idle} = 4'h0;
    {want_lfps, addr, wdata, mode_level, lag, snoop_lane_mask} = 26'h0;
    {upstream_gain_pins, downstream_gain_pins, lane_gain_pins} = 12'h000;
    {u, d, l, bad_count, tests_run, cycles, det_seen} = 0;
    void'($urandom(70));
    for (i = 0; i < 4; i++)
    begin
      u = 4'($urandom);
      d = 4'($urandom);
      l = {2'($urandom), i[1:0]};
      powerup(2'h0);
      #1;
      `CHK("target_addr", exp_addr(l[1:0], d[1:0]), target_addr)
      `CHK("gains", {l, l, l, l, u, u, d}, {lane0_gain, lane1_gain, lane2_gain, lane3_gain, upstream1_gain, upstream2_gain, downstream_gain})
      `CHK("route", exp_route(0, 1, 0), {usb_pair, lane0_source, lane1_source, lane2_source, lane3_source})
    end
    `CHK("bias", 1'b1, bias_enable)
    repeat (CFG_HOLD_CYC + 5) @(posedge clk);
    #1;
    `CHK("bias", 1'b0, bias_enable)
    @(posedge clk);
    usb_enable_pin <= 1'b1;
    repeat (12) @(posedge clk);
    usb_enable_pin <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    `CHK("route", exp_route(0, 0, 0), {usb_pair, lane0_source, lane1_source, lane2_source, lane3_source})
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      {dp_enable_pin, orientation_pin, usb_enable_pin} <= 3'(i);
      hot_plug_input <= 1'($urandom);
      snoop_lane_mask <= 4'($urandom);
      repeat (12) @(posedge clk);
      #1;
      `CHK("route", exp_route(i[2], i[0], i[1]), {usb_pair, lane0_source, lane1_source, lane2_source, lane3_source})
      `CHK("sbu", exp_sbu(2'h0, i[2], i[1]), sbu_map)
      `CHK("lanes", (i[2] & hot_plug_input) ? (i[0] ? 4'h3 : 4'hF) : 4'h0, lane_active)
    end
    powerup(2'h1 + 2'($urandom_range(0, 2)));
    rd_chk(REG_CONFIG, 8'h01, 8'hFF);
    rd_chk(REG_TARGET, {1'b0, exp_addr(l[1:0], d[1:0])}, 8'h7F);
    rd_chk(8'h3F, 8'h00, 8'hFF);
    `CHK("route", exp_route(0, 1, 0), {usb_pair, lane0_source, lane1_source, lane2_source, lane3_source})
    for (i = 0; i < 32; i++)
    begin
      off = (i < 8) ? 4'h0 : 4'($urandom);
      cfg = {2'h0, 1'($urandom) | (i < 8), 5'(i)};
      @(posedge clk);
      hot_plug_input <= 1'($urandom);
      snoop_lane_mask <= 4'($urandom);
      wr_reg(REG_LANE_OFF, {4'h0, off});
      wr_reg(REG_CONFIG, cfg);
      repeat (2) @(posedge clk);
      #1;
      `CHK("route", exp_route(i[1], i[0], i[2]), {usb_pair, lane0_source, lane1_source, lane2_source, lane3_source})
      `CHK("sbu", exp_sbu(i[4:3], i[1], i[2]), sbu_map)
      if (i[1:0] == 2'h2)
        `CHK("lanes", hot_plug_input ? (cfg[5] ? ~{off[0], off[1], off[2], off[3]} : snoop_lane_mask) : 4'h0, lane_active)
      if (i[1:0] == 2'h3)
        `CHK("lanes", hot_plug_input ? (cfg[5] ? ~off : snoop_lane_mask) & 4'h3 : 4'h0, lane_active)
      if (!i[1])
        `CHK("lanes", 4'h0, lane_active)
      rd_chk(REG_CONFIG, cfg, 8'h3F);
    end
    g = $urandom;
    @(posedge clk);
    wr_reg(REG_LANE_GAIN01, g[7:0]);
    wr_reg(REG_LANE_GAIN23, g[15:8]);
    wr_reg(REG_UP_GAIN, g[23:16]);
    wr_reg(REG_DOWN_GAIN, g[31:24]);
    repeat (2) @(posedge clk);
    #1;
    `CHK("gains", {g[3:0], g[7:4], g[11:8], g[15:12], g[19:16], g[23:20], g[27:24]}, {lane0_gain, lane1_gain, lane2_gain, lane3_gain, upstream1_gain, upstream2_gain, downstream_gain})
    rd_chk(REG_LANE_GAIN23, g[15:8], 8'hFF);
    @(posedge clk);
    lag <= 3'($urandom);
    want_term <= 1'b1;
    wr_reg(REG_CONFIG, 8'h20);
    repeat (20) @(posedge clk);
    #1;
    `CHK("link_off", LINK_DISC, link_state)
    @(posedge clk);
    wr_reg(REG_CONFIG, 8'h21);
    wait_link(LINK_U0, 20);
    `CHK("redrive", 1'b1, redrive_en)
    @(posedge clk);
    want_idle <= 1'b1;
    wait_link(LINK_U1, 20);
    `CHK("u1_levels", 2'h3, {rx_term_en, tx_cm_en})
    pulse_lfps();
    wait_link(LINK_U0, 10);
    wait_link(LINK_U23, 250);
    `CHK("u23_levels", 2'h2, {rx_term_en, tx_cm_en})
    pulse_lfps();
    wait_link(LINK_U0, 10);
    wait_link(LINK_U23, 250);
    @(posedge clk);
    want_term <= 1'b0;
    det_seen = 1'b0;
    wait_link(LINK_DISC, 1100);
    `CHK("rx_detect", 1'b1, det_seen)
    print_verdict();
  end
endmodule : tcx_config_control_tb

// File: tcx_link_partner.sv
`timescale 1ns/1ns
module tcx_link_partner
(
  input wire logic clk,
  input wire logic want_term,
  input wire logic want_idle,
  input wire logic want_lfps,
  input wire logic [2:0] lag,
  output logic far_term_up,
  output logic far_term_down,
  output logic idle_up,
  output logic idle_down,
  output logic lfps_valid
);
  logic [7:0] term_hist = 8'h00;
  logic [7:0] idle_hist = 8'h00;

  // The downstream port trails the upstream one by lag cycles, so the
  // tracker never sees both ports change in the same cycle unless lag is 0.
  always_ff @(posedge clk)
  begin
    term_hist <= {term_hist[6:0], want_term};
    idle_hist <= {idle_hist[6:0], want_idle};
    lfps_valid <= want_lfps;
  end

  assign far_term_up = term_hist[0];
  assign idle_up = idle_hist[0];
  assign far_term_down = term_hist[lag];
  assign idle_down = idle_hist[lag];
endmodule : tcx_link_partner

// File: tcx_pkg.sv
package tcx_pkg;
  // Clock and timing figures.
  localparam int CLK_MHZ = 100;
  localparam int PG_DELAY_US = 500;
  localparam int PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
  localparam int CFG_HOLD_US = 10;
  localparam int CFG_HOLD_CYC = CFG_HOLD_US * CLK_MHZ;
  localparam int DEBOUNCE_MS = 16;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int U1_IDLE_US = 2;
  localparam int U1_IDLE_CYC = U1_IDLE_US * CLK_MHZ;
  localparam int RXDET_US = 10;
  localparam int RXDET_CYC = RXDET_US * CLK_MHZ;

  // Register offsets.
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_LANE_OFF = 8'h01;
  localparam logic [7:0] REG_LANE_GAIN01 = 8'h02;
  localparam logic [7:0] REG_LANE_GAIN23 = 8'h03;
  localparam logic [7:0] REG_UP_GAIN = 8'h04;
  localparam logic [7:0] REG_DOWN_GAIN = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h06;
  localparam logic [7:0] REG_TARGET = 8'h07;

  // Fields of the configuration register.
  localparam int CFG_USB_BIT = 0;
  localparam int CFG_DP_BIT = 1;
  localparam int CFG_FLIP_BIT = 2;
  localparam int CFG_SBU_LSB = 3;
  localparam int CFG_SNOOP_OFF_BIT = 5;
  localparam logic [7:0] CONFIG_RST = 8'h01;
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [3:0] LANE_OFF_RST = 4'h0;

  // Four-level pin codes and sideband override values.
  localparam logic [1:0] LVL_0 = 2'h0;
  localparam logic [1:0] LVL_R = 2'h1;
  localparam logic [1:0] LVL_F = 2'h2;
  localparam logic [1:0] SBU_AUTO = 2'h0;
  localparam logic [1:0] SBU_STRAIGHT = 2'h1;
  localparam logic [1:0] SBU_SWAPPED = 2'h2;
  localparam logic [1:0] SBU_OPEN = 2'h0;

  // High patterns of the serial target address, by upper pin level.
  localparam logic [6:0] ADDR_HI_0 = 7'h44;
  localparam logic [6:0] ADDR_HI_R = 7'h20;
  localparam logic [6:0] ADDR_HI_F = 7'h10;
  localparam logic [6:0] ADDR_HI_1 = 7'h0C;

  // USB pair selection.
  localparam logic [1:0] PAIR_NONE = 2'h0;
  localparam logic [1:0] PAIR_ONE = 2'h1;
  localparam logic [1:0] PAIR_TWO = 2'h2;

  typedef enum logic [1:0] {
    LINK_DISC = 2'b00,
    LINK_U0 = 2'b01,
    LINK_U1 = 2'b10,
    LINK_U23 = 2'b11
  } tcx_link_t;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_TX1 = 3'b001,
    SRC_RX1 = 3'b010,
    SRC_TX2 = 3'b011,
    SRC_RX2 = 3'b100
  } tcx_src_t;
endpackage : tcx_pkg
